// >>> hw/dbl_host.sv
// bus-side controller that loads a double-buffered converter through its latch strobes
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// How it works
// - on an 8-bit bus every word goes out as exactly two separate writes
// - right justified: low byte group first, high group second
// - left justified: high byte group first, low group second
// - justify select pin high means left, low means right, held steady
// - the reduced part is left justified only, so high group goes first
// - a shared update strobe lets several converters update together
// - a 16-bit bus offers single buffered, double buffered or flow-through loading
// - flow-through needs strobes and select low, half word select high
// - on a 16-bit bus half word select stays high, one write loads all
module dbl_host (
    input logic mclk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic ext_update_n,
    output dbl_pkg::dbl_pins_t pins
);
    typedef enum {H_IDLE, H_FIRST, H_SECOND, H_UPDATE_STROBE_N} dbl_host_state_t;
    dbl_host_state_t state;
    dbl_pkg::dbl_mode_t mode;
    logic left;
    logic reduced;
    logic [9:0] word;
    logic overrun;
    logic pending;
    logic op_updates;
    logic [15:0] bus;
    dbl_pkg::dbl_strobe_t seq_mask;
    dbl_pkg::dbl_strobe_t seq_active;
    logic seq_busy;
    logic seq_done;

    // address decode and access qualifiers
    wire setup_ph = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_ctrl = (paddr == dbl_pkg::CTRL_OFS);
    wire hit_data = (paddr == dbl_pkg::DATA_OFS);
    wire hit_update_strobe_n = (paddr == dbl_pkg::UPDATE_STROBE_N_OFS);
    wire hit_stat = (paddr == dbl_pkg::STAT_OFS);
    wire mapped = hit_ctrl | hit_data | hit_update_strobe_n | hit_stat;

    wire busy = (state != H_IDLE);
    wire eff_left = left | reduced;
    wire is8 = (mode == dbl_pkg::MODE_AUTO) | (mode == dbl_pkg::MODE_COMMON) |
               (mode == dbl_pkg::MODE_EXTERN);
    wire is_flow = (mode == dbl_pkg::MODE_FLOW);
    wire is_ext = (mode == dbl_pkg::MODE_EXTERN);
    wire update_strobe_n_mode = (mode == dbl_pkg::MODE_COMMON) | (mode == dbl_pkg::MODE_W16_DOUBLE);
    wire mode_ok = (pwdata[2:0] <= 3'(dbl_pkg::MODE_FLOW));

    // a mode change mid-sequence would tear a word in half, so it is dropped
    wire ctrl_we = wr & hit_ctrl & ~busy & mode_ok;
    wire data_we = wr & hit_data & ~busy;
    wire start_data = data_we & ~is_flow;
    wire start_update_strobe_n = wr & hit_update_strobe_n & ~busy & pending & update_strobe_n_mode;
    wire refused = wr & (hit_data | hit_update_strobe_n) & busy;
    wire ovr_clr = wr & hit_stat & pwdata[dbl_pkg::STAT_OVR_BIT];
    wire first_done = (state == H_FIRST) & seq_done;
    wire seq_start = start_data | start_update_strobe_n | first_done;

    assign seq_mask.in_latch = ~start_update_strobe_n;
    // single buffered 16-bit and the automatic second write move the word across at once
    assign seq_mask.dac_reg = start_update_strobe_n |
        (start_data & (mode == dbl_pkg::MODE_W16_SINGLE)) |
        (first_done & (mode == dbl_pkg::MODE_AUTO));

    wire [31:0] rd_ctrl = {27'h0000000, reduced, left, mode};
    wire [31:0] rd_data = {22'h000000, word};
    wire [31:0] rd_stat = {29'h00000000, pending, overrun, busy};
    wire [31:0] rd_val = hit_ctrl ? rd_ctrl : hit_data ? rd_data : hit_stat ? rd_stat : 32'h0;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    dbl_strobe u_strobe (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(seq_start),
        .mask(seq_mask),
        .active(seq_active),
        .busy(seq_busy),
        .done(seq_done)
    );

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            mode <= dbl_pkg::MODE_RESET;
            left <= dbl_pkg::LEFT_RESET;
            reduced <= dbl_pkg::REDUCED_RESET;
            word <= 10'h000;
            overrun <= 1'b0;
        end else begin
            if (setup_ph) begin
                prdata <= rd_val;
            end
            if (ctrl_we) begin
                mode <= dbl_pkg::dbl_mode_t'(pwdata[2:0]);
                left <= pwdata[dbl_pkg::CTRL_LEFT_BIT];
                reduced <= pwdata[dbl_pkg::CTRL_REDUCED_BIT];
            end
            if (data_we) begin
                word <= pwdata[9:0];
            end
            // a refused write in the clearing cycle still leaves the flag set
            overrun <= refused | (overrun & ~ovr_clr);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= H_IDLE;
            pending <= 1'b0;
            op_updates <= 1'b0;
            bus <= 16'h0000;
        end else begin
            if (seq_start) begin
                op_updates <= seq_mask.dac_reg;
            end
            case (state)
                H_IDLE: begin
                    if (start_data && is8) begin
                        bus <= {8'h00, dbl_pkg::byte_of(pwdata[9:0], eff_left, 1'b0)};
                        state <= H_FIRST;
                    end else if (start_data) begin
                        bus <= dbl_pkg::word16(pwdata[9:0], eff_left);
                        state <= H_SECOND;
                    end else if (start_update_strobe_n) begin
                        state <= H_UPDATE_STROBE_N;
                    end else if (is_flow) begin
                        bus <= dbl_pkg::word16(word, eff_left);
                    end
                end
                H_FIRST: begin
                    if (seq_done) begin
                        bus <= {8'h00, dbl_pkg::byte_of(word, eff_left, 1'b1)};
                        state <= H_SECOND;
                    end
                end
                H_SECOND: begin
                    if (seq_done) begin
                        pending <= ~op_updates;
                        state <= H_IDLE;
                    end
                end
                H_UPDATE_STROBE_N: begin
                    if (seq_done) begin
                        pending <= 1'b0;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // pins are registered one cycle behind the sequencer, keeping data ahead of strobes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pins <= dbl_pkg::PINS_IDLE;
        end else begin
            pins.cs_n <= ~is_flow & ~(seq_active.in_latch | seq_active.dac_reg);
            pins.first_stage_write_n <= ~is_flow & ~seq_active.in_latch;
            // external mode leaves the register enable open; the outside strobe decides
            pins.second_stage_write_n <= ~is_flow & ~is_ext & ~seq_active.dac_reg;
            pins.update_strobe_n <= is_flow ? 1'b0 :
                is_ext ? ext_update_n : ~seq_active.dac_reg;
            pins.half_word_select <= (state != H_SECOND) | ~is8;
            pins.justify_select <= eff_left;
            pins.data <= bus;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // first latch strobe one cycle back, to spot its falling edge
    logic wr1_prev;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr1_prev <= 1'b1;
        end else begin
            wr1_prev <= pins.first_stage_write_n;
        end
    end
    wire wr1_fell = wr1_prev & ~pins.first_stage_write_n;

    two_writes_a: assert property (wr1_fell && pins.half_word_select && is8 |->
        ##[1:40] ($fell(pins.first_stage_write_n) && !pins.half_word_select))
        else $error("first byte write not followed by a second write");
    right_first_a: assert property (wr1_fell && pins.half_word_select && is8 && !eff_left |->
        pins.data[7:0] == word[7:0])
        else $error("right justified first write is not the low byte");
    left_first_a: assert property (wr1_fell && pins.half_word_select && is8 && eff_left |->
        pins.data[7:0] == word[9:2])
        else $error("left justified first write is not the high group");
    second_group_a: assert property (wr1_fell && !pins.half_word_select |->
        pins.data[7:0] == dbl_pkg::byte_of(word, eff_left, 1'b1))
        else $error("second write carries the wrong two bits");
    reduced_left_a: assert property (reduced |=> pins.justify_select)
        else $error("reduced part not driven left justified");
    auto_update_a: assert property (wr1_fell && !pins.half_word_select &&
        mode == dbl_pkg::MODE_AUTO |-> !pins.update_strobe_n && !pins.second_stage_write_n)
        else $error("automatic mode second write did not transfer");
    common_update_strobe_n_a: assert property (start_update_strobe_n |-> ##[2:5] (!pins.update_strobe_n &&
        !pins.second_stage_write_n && pins.first_stage_write_n))
        else $error("shared update strobe not issued");
    w16_single_a: assert property (wr1_fell && mode == dbl_pkg::MODE_W16_SINGLE |->
        !pins.update_strobe_n && pins.half_word_select &&
        pins.data == dbl_pkg::word16(word, eff_left))
        else $error("single buffered write malformed");
    flow_pins_a: assert property (is_flow |=> (!pins.cs_n && !pins.first_stage_write_n &&
        !pins.second_stage_write_n && !pins.update_strobe_n && pins.half_word_select))
        else $error("flow-through pins not held");
    seq_busy_a: assert property (seq_busy |-> busy)
        else $error("strobe sequencer running while controller idle");

    auto_pair_c: cover property (mode == dbl_pkg::MODE_AUTO && start_data ##[1:40] seq_done);
    common_c: cover property (start_update_strobe_n);
    flow_c: cover property (is_flow && data_we);
    overrun_c: cover property (refused && ovr_clr);
endmodule

// >>> hw/dbl_pkg.sv
// constants, types and helpers for the two-write converter load controller
package dbl_pkg;
    localparam int CLK_MHZ = 20;
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 500;
    localparam int HOLD_NS = 50;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
    localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
    localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);

    localparam int WORD_W = 10;
    localparam int BYTE_W = 8;
    localparam int BUS_W = 16;
    localparam int ADDR_W = 8;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DATA_OFS = 8'h04;
    localparam logic [7:0] UPDATE_STROBE_N_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_LEFT_BIT = 3;
    localparam int CTRL_REDUCED_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OVR_BIT = 1;
    localparam int STAT_PEND_BIT = 2;

    typedef enum logic [2:0] {
        MODE_AUTO,
        MODE_COMMON,
        MODE_EXTERN,
        MODE_W16_SINGLE,
        MODE_W16_DOUBLE,
        MODE_FLOW
    } dbl_mode_t;

    localparam dbl_mode_t MODE_RESET = MODE_AUTO;
    localparam logic LEFT_RESET = 1'b0;
    localparam logic REDUCED_RESET = 1'b0;

    typedef struct packed {
        logic cs_n;
        logic first_stage_write_n;
        logic second_stage_write_n;
        logic update_strobe_n;
        logic half_word_select;
        logic justify_select;
        logic [BUS_W-1:0] data;
    } dbl_pins_t;

    typedef struct packed {
        logic in_latch;
        logic dac_reg;
    } dbl_strobe_t;

    localparam dbl_pins_t PINS_IDLE = '{cs_n: 1'b1, first_stage_write_n: 1'b1,
        second_stage_write_n: 1'b1, update_strobe_n: 1'b1, half_word_select: 1'b1,
        justify_select: 1'b0, data: 16'h0000};

    // byte group for the first or second write of an 8-bit pair
    function automatic logic [BYTE_W-1:0] byte_of(input logic [WORD_W-1:0] w,
                                                  input logic left, input logic second);
        if (left) begin
            return second ? {w[1:0], 6'h00} : w[9:2];
        end
        return second ? {6'h00, w[9:8]} : w[7:0];
    endfunction

    // placement of the word on a 16-bit bus, surplus bits zero
    function automatic logic [BUS_W-1:0] word16(input logic [WORD_W-1:0] w, input logic left);
        return left ? {w, 6'h00} : {6'h00, w};
    endfunction
endpackage

// >>> hw/dbl_strobe.sv
// write strobe sequencer: data setup, strobe pulse, data hold
`timescale 1ns/1ps
module dbl_strobe (
    input logic mclk,
    input logic sys_rst,
    input logic start,
    input dbl_pkg::dbl_strobe_t mask,
    output dbl_pkg::dbl_strobe_t active,
    output logic busy,
    output logic done
);
    typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD} dbl_seq_t;
    dbl_seq_t state;
    logic [7:0] cnt;
    dbl_pkg::dbl_strobe_t held;
    wire cnt_zero = (cnt == 8'h00);

    assign busy = (state != S_IDLE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cnt <= 8'h00;
            held <= '0;
            active <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        held <= mask;
                        cnt <= 8'(dbl_pkg::SETUP_CYC - 1);
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (cnt_zero) begin
                        active <= held;
                        cnt <= 8'(dbl_pkg::STROBE_CYC - 1);
                        state <= S_PULSE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_PULSE: begin
                    if (cnt_zero) begin
                        active <= '0;
                        cnt <= 8'(dbl_pkg::HOLD_CYC - 1);
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt_zero) begin
                        done <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // cycles the strobe has stood so far; a counter keeps the width check cheap to unroll
    logic [7:0] act_len;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_len <= 8'h00;
        end else if (|active) begin
            act_len <= act_len + 8'h01;
        end else begin
            act_len <= 8'h00;
        end
    end

    strobe_width_a: assert property ($fell(|active) |-> act_len == 8'(dbl_pkg::STROBE_CYC))
        else $error("write strobe width is not ten cycles");
endmodule

// >>> tb/dbl_conv_model.sv
// behavioural model of the converter's two latch stages, driven from the controller pins
`timescale 1ns/1ps
module dbl_conv_model (
    input dbl_pkg::dbl_pins_t pins,
    input wire logic wide,
    output logic [9:0] dac_out
);
    // no initial value: both stages power up unknown, so a missed load stays visible
    logic [9:0] in_latch;
    wire load_en = !pins.cs_n && !pins.first_stage_write_n;
    wire update_strobe_n_en = !pins.second_stage_write_n && !pins.update_strobe_n;
    wire left = pins.justify_select;
    // board wiring: 16-bit bus uses ten lines, 8-bit bus repeats two lines for the pair
    wire [9:0] w16 = left ? pins.data[15:6] : pins.data[9:0];
    wire [9:0] w8 = left ? {pins.data[7:0], pins.data[7:6]} : {pins.data[1:0], pins.data[7:0]};

    always_latch begin
        if (load_en && pins.half_word_select) begin
            in_latch = wide ? w16 : w8;
        end else if (load_en && left) begin
            in_latch[1:0] = pins.data[7:6];
        end else if (load_en) begin
            in_latch[9:8] = pins.data[1:0];
        end
    end

    // output moves only through this stage; it follows while enabled, holds otherwise
    always_latch begin
        if (update_strobe_n_en) begin
            dac_out = in_latch;
        end
    end
endmodule

// >>> tb/tb_dbl_host.sv
// self-checking bench for the converter load controller
`timescale 1ns/1ps
module tb_dbl_host;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, ext_update_n, wide, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] dac_out, old;
    dbl_pkg::dbl_pins_t pins;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam int LIMIT = 20000;

    dbl_host dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_update_n(ext_update_n), .pins(pins));
    dbl_conv_model conv_u (.pins(pins), .wide(wide), .dac_out(dac_out));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task conclude;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang in any wait lands here
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            conclude();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_idle;
        for (int n = 0; n < 100; n++) begin
            apb(1'b0, dbl_pkg::STAT_OFS, 32'h0);
            if (rd[dbl_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        check(rd[dbl_pkg::STAT_BUSY_BIT], 1'b0, "went idle");
    endtask

    task set_mode(input dbl_pkg::dbl_mode_t m, input logic l, input logic r);
        apb(1'b1, dbl_pkg::CTRL_OFS, 32'(m) | (32'(l) << dbl_pkg::CTRL_LEFT_BIT)
            | (32'(r) << dbl_pkg::CTRL_REDUCED_BIT));
        wide <= (m >= dbl_pkg::MODE_W16_SINGLE);
    endtask

    task load(input logic [9:0] w);
        apb(1'b1, dbl_pkg::DATA_OFS, {22'h0, w});
        wait_idle();
    endtask

    task t_reset;
        check(32'(pins), 32'(dbl_pkg::PINS_IDLE), "idle pins");
        apb(1'b0, dbl_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0, "ctrl reset");
    endtask

    // byte pair in each justification, output frozen between the writes
    task t_auto;
        logic [9:0] words [3] = '{10'h3ff, 10'h2a5, 10'h16c};
        logic lj [3] = '{1'b0, 1'b1, 1'b0};
        logic rv [3] = '{1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 3; i++) begin
            set_mode(dbl_pkg::MODE_AUTO, lj[i], rv[i]);
            old = dac_out;
            apb(1'b1, dbl_pkg::DATA_OFS, {22'h0, words[i]});
            repeat (2) @(posedge mclk);
            check(pins.data[7:0], (lj[i] | rv[i]) ? words[i][9:2] : words[i][7:0], "1st");
            check(pins.justify_select, lj[i] | rv[i], "justify");
            repeat (12) @(posedge mclk);
            check(dac_out, old, "early update");
            repeat (3) @(posedge mclk);
            check(pins.half_word_select, 1'b0, "2nd write");
            check(pins.data[7:0], (lj[i] | rv[i]) ? {words[i][1:0], 6'h00} :
                {6'h00, words[i][9:8]}, "2nd");
            wait_idle();
            check(dac_out, words[i], "auto word");
        end
    endtask

    // transfer by register strobe or external strobe; later loads must not leak out
    task t_sync(input dbl_pkg::dbl_mode_t m, input logic [9:0] w);
        set_mode(m, 1'b0, 1'b0);
        old = dac_out;
        load(w);
        check(dac_out, old, "before transfer");
        check(rd[dbl_pkg::STAT_PEND_BIT], 1'b1, "pending");
        if (m == dbl_pkg::MODE_EXTERN) begin
            ext_update_n <= 1'b0;
            repeat (4) @(posedge mclk);
            ext_update_n <= 1'b1;
            repeat (3) @(posedge mclk);
        end else begin
            apb(1'b1, dbl_pkg::UPDATE_STROBE_N_OFS, 32'h0);
            wait_idle();
        end
        check(dac_out, w, "after transfer");
        load(~w);
        check(dac_out, w, "hold");
    endtask

    task t_w16;
        for (int l = 0; l < 2; l++) begin
            set_mode(dbl_pkg::MODE_W16_SINGLE, l[0], 1'b0);
            load(10'h201 + 10'(l));
            check(dac_out, 10'h201 + 10'(l), "w16 single");
            check(pins.half_word_select, 1'b1, "half select");
        end
    endtask

    task t_flow;
        set_mode(dbl_pkg::MODE_FLOW, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, dbl_pkg::DATA_OFS, 32'h0c3 << i);
            repeat (3) @(posedge mclk);
            check(dac_out, 10'h0c3 << i, "flow");
            check({pins.cs_n, pins.update_strobe_n, pins.half_word_select}, 3'h1, "flow pins");
        end
    endtask

    // dropped write, sticky flag, unmapped address, illegal mode
    task t_refuse;
        set_mode(dbl_pkg::MODE_AUTO, 1'b0, 1'b0);
        apb(1'b1, dbl_pkg::DATA_OFS, 32'h155);
        apb(1'b1, dbl_pkg::DATA_OFS, 32'h0aa);
        wait_idle();
        check(dac_out, 10'h155, "busy write");
        check(rd[dbl_pkg::STAT_OVR_BIT], 1'b1, "overrun");
        apb(1'b1, dbl_pkg::STAT_OFS, 32'h1 << dbl_pkg::STAT_OVR_BIT);
        apb(1'b0, dbl_pkg::STAT_OFS, 32'h0);
        check(rd[dbl_pkg::STAT_OVR_BIT], 1'b0, "overrun clear");
        apb(1'b0, 8'h10, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped");
        apb(1'b1, dbl_pkg::CTRL_OFS, 32'h6);
        apb(1'b0, dbl_pkg::CTRL_OFS, 32'h0);
        check(rd[2:0], 3'h0, "bad mode");
    endtask

    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_update_n = 1'b1;
        wide = 1'b0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_auto();
        t_sync(dbl_pkg::MODE_COMMON, 10'h3c1);
        t_sync(dbl_pkg::MODE_EXTERN, 10'h08e);
        t_sync(dbl_pkg::MODE_W16_DOUBLE, 10'h2f0);
        t_w16();
        t_flow();
        t_refuse();
        conclude();
    end
endmodule
